// file: verilog/bpsc_pkg.sv
// Constants, field positions and state types of the backup power switchover control.
// Assumes a single 250 MHz clock and a two-wire serial slave on the register side.
package bpsc_pkg;

   // Two-wire slave address (7 bits)
   localparam logic [6:0] BPSC_SLAVE_ADDR = 7'h68;

   // Register offsets
   localparam logic [4:0] BPSC_ADDR_OUT_CTRL = 5'h07;
   localparam logic [4:0] BPSC_ADDR_PWR_CTRL = 5'h08;
   localparam logic [4:0] BPSC_ADDR_PWR_STAT = 5'h0B;
   localparam logic [4:0] BPSC_ADDR_PAGE_LAST = 5'h07;
   localparam logic [4:0] BPSC_ADDR_ZERO = 5'h00;

   // Field positions
   localparam int BPSC_OUT_BIT = 7;
   localparam int BPSC_FSEL_BIT = 6;
   localparam int BPSC_ALME_BIT = 6;
   localparam int BPSC_LP_BIT = 5;
   localparam int BPSC_SEAL_BIT = 5;
   localparam int BPSC_BAT_BIT = 1;
   localparam int BPSC_PLOSS_BIT = 0;

   // Reset values
   localparam logic [7:0] BPSC_OUT_CTRL_RST = 8'h80;
   localparam logic [7:0] BPSC_PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] BPSC_PWR_STAT_RST = 8'h03;

   // Timing
   localparam int BPSC_CLK_HZ = 250_000_000;
   localparam int BPSC_FOUT_HZ = 512;
   localparam int BPSC_FOUT_HALF_CYC = BPSC_CLK_HZ / (2 * BPSC_FOUT_HZ);
   localparam int BPSC_FOUT_CNT_W = 18;

   // Synchroniser width: scl, sda and four comparator flags
   localparam int BPSC_SYNC_W = 6;

   typedef enum logic [1:0] {PM_SEALED, PM_MAIN, PM_BACKUP} bpsc_pm_e;
   typedef enum logic [2:0] {BS_IDLE, BS_DEV, BS_PTR, BS_WR, BS_RD} bpsc_bus_e;

endpackage : bpsc_pkg

// file: verilog/bpsc_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no bus coherency between bits.
`timescale 1ns/10ps
`default_nettype none
module bpsc_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Levels
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge i_mclk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= i_async[g];
               sync_q <= meta_q;
            end
         end
         assign o_sync[g] = sync_q;
      end
   endgenerate
endmodule : bpsc_sync
`default_nettype wire

// file: verilog/bpsc_top.sv
// Supply switchover control with two-wire register slave and dual-function output pin.
// Assumes digitised supply comparators and bus pins; pins and flags synchronised here.
`timescale 1ns/10ps
`default_nettype none
module bpsc_top
   import bpsc_pkg::*;
#(
   parameter int FOUT_HALF = BPSC_FOUT_HALF_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Supply comparators
   input wire logic i_vdd_lt_bat_hys,
   input wire logic i_vdd_lt_trip,
   input wire logic i_vdd_gt_bat_hys,
   input wire logic i_vdd_gt_trip_hys,
   // Two-wire bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Output pin
   output logic o_fout_o,
   output logic o_fout_oe,
   // Supply control
   output logic o_backup_en,
   output logic o_on_main,
   output logic o_bus_rx_en,
   output logic o_trip_mon_en
);

   function automatic logic [4:0] next_ptr(input logic [4:0] p);
      next_ptr = (p == BPSC_ADDR_PAGE_LAST) ? BPSC_ADDR_ZERO : p + 5'h01;
   endfunction : next_ptr

   logic out_q, fsel_q, alme_q, lp_q, seal_q, bat_q, ploss_q;
   logic [5:0] trim_q;

   function automatic logic [7:0] rd_mux(input logic [4:0] a, input logic o, input logic f,
         input logic [5:0] t, input logic al, input logic l, input logic s, input logic b,
         input logic r);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         BPSC_ADDR_OUT_CTRL: v = {o, f, t};
         BPSC_ADDR_PWR_CTRL: v = {1'b0, al, l, 5'h00};
         BPSC_ADDR_PWR_STAT: v = {2'b00, s, 3'b000, b, r};
         default: v = 8'h00;
      endcase
      rd_mux = v;
   endfunction : rd_mux

   // Input synchronisation
   logic [BPSC_SYNC_W-1:0] sync;
   bpsc_sync #(.W(BPSC_SYNC_W)) u_sync (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_async({i_scl, i_sda, i_vdd_lt_bat_hys, i_vdd_lt_trip, i_vdd_gt_bat_hys,
                i_vdd_gt_trip_hys}),
      .o_sync(sync)
   );
   logic scl_s, sda_s, lt_bat, lt_trip, gt_bat, gt_trip;
   assign {scl_s, sda_s, lt_bat, lt_trip, gt_bat, gt_trip} = sync;

   // Bus slave state
   bpsc_bus_e bs_q, bs_d;
   logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic ack_q, ack_d, rw_q, rw_d, sda_oe_q, sda_oe_d;
   logic [4:0] ptr_q, ptr_d;
   bpsc_pm_e pm_q, pm_d;
   logic scl_rise, scl_fall, bus_start, bus_stop, wr_stb;
   logic [7:0] rd_now;

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign wr_stb = (bs_q == BS_WR) & scl_fall & (cnt_q == 4'h8) & ~ack_q;
   assign rd_now = rd_mux(ptr_q, out_q, fsel_q, trim_q, alme_q, lp_q, seal_q, bat_q, ploss_q);

   always_comb begin
      bs_d = bs_q;
      scl_p_d = scl_s;
      sda_p_d = sda_s;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ack_d = ack_q;
      rw_d = rw_q;
      sda_oe_d = sda_oe_q;
      ptr_d = ptr_q;
      if (pm_q != PM_MAIN) begin
         bs_d = BS_IDLE;
         sda_oe_d = 1'b0;
         cnt_d = 4'h0;
         ack_d = 1'b0;
      end else if (bus_start) begin
         bs_d = BS_DEV;
         cnt_d = 4'h0;
         ack_d = 1'b0;
         sda_oe_d = 1'b0;
      end else if (bus_stop) begin
         bs_d = BS_IDLE;
         sda_oe_d = 1'b0;
      end else if (bs_q == BS_RD) begin
         if (ack_q) begin
            if (scl_rise && sda_s) begin
               bs_d = BS_IDLE;
            end else if (scl_fall) begin
               sh_d = rd_now;
               sda_oe_d = ~rd_now[7];
               cnt_d = 4'h0;
               ack_d = 1'b0;
            end
         end else if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
         end else if (scl_fall) begin
            if (cnt_q == 4'h8) begin
               sda_oe_d = 1'b0;
               ack_d = 1'b1;
               ptr_d = next_ptr(ptr_q);
            end else begin
               sh_d = {sh_q[6:0], 1'b0};
               sda_oe_d = ~sh_q[6];
            end
         end
      end else if (bs_q != BS_IDLE) begin
         if (ack_q) begin
            if (scl_fall) begin
               sda_oe_d = 1'b0;
               ack_d = 1'b0;
               cnt_d = 4'h0;
               if (bs_q == BS_DEV && rw_q) begin
                  bs_d = BS_RD;
                  sh_d = rd_now;
                  sda_oe_d = ~rd_now[7];
               end else if (bs_q == BS_DEV) begin
                  bs_d = BS_PTR;
               end else begin
                  bs_d = BS_WR;
               end
            end
         end else if (scl_rise && cnt_q != 4'h8) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
         end else if (scl_fall && cnt_q == 4'h8) begin
            ack_d = 1'b1;
            sda_oe_d = 1'b1;
            case (bs_q)
               BS_DEV: begin
                  rw_d = sh_q[0];
                  if (sh_q[7:1] != BPSC_SLAVE_ADDR) begin
                     bs_d = BS_IDLE;
                     ack_d = 1'b0;
                     sda_oe_d = 1'b0;
                  end
               end
               BS_PTR: ptr_d = sh_q[4:0];
               BS_WR: ptr_d = next_ptr(ptr_q);
               default: bs_d = BS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bs_q <= BS_IDLE;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
         rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
         ptr_q <= BPSC_ADDR_ZERO;
      end else begin
         bs_q <= bs_d;
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ack_q <= ack_d;
         rw_q <= rw_d;
         sda_oe_q <= sda_oe_d;
         ptr_q <= ptr_d;
      end
   end

   // Registers and supply mode
   logic out_d, fsel_d, alme_d, lp_d, seal_d, bat_d, ploss_d;
   logic [5:0] trim_d;
   logic enter_bk, leave_bk, backup_en_d, on_main_d, rx_en_d, trip_mon_d;

   always_comb begin
      out_d = out_q;
      fsel_d = fsel_q;
      trim_d = trim_q;
      alme_d = alme_q;
      lp_d = lp_q;
      seal_d = seal_q;
      bat_d = bat_q;
      ploss_d = ploss_q;
      pm_d = pm_q;
      if (wr_stb) begin
         case (ptr_q)
            BPSC_ADDR_OUT_CTRL: begin
               out_d = sh_q[BPSC_OUT_BIT];
               fsel_d = sh_q[BPSC_FSEL_BIT];
               trim_d = sh_q[5:0];
            end
            BPSC_ADDR_PWR_CTRL: begin
               alme_d = sh_q[BPSC_ALME_BIT];
               lp_d = sh_q[BPSC_LP_BIT];
            end
            BPSC_ADDR_PWR_STAT: begin
               seal_d = seal_q | sh_q[BPSC_SEAL_BIT];
               bat_d = bat_q & sh_q[BPSC_BAT_BIT];
               ploss_d = ploss_q & sh_q[BPSC_PLOSS_BIT];
            end
            default: begin
            end
         endcase
      end
      enter_bk = lp_q ? lt_bat : (lt_bat & lt_trip);
      leave_bk = gt_bat | (~lp_q & gt_trip);
      case (pm_q)
         PM_MAIN: begin
            if (enter_bk) begin
               pm_d = seal_d ? PM_SEALED : PM_BACKUP;
            end
         end
         PM_BACKUP: begin
            bat_d = 1'b1;
            if (leave_bk) begin
               pm_d = PM_MAIN;
            end
         end
         PM_SEALED: begin
            if (leave_bk) begin
               pm_d = PM_MAIN;
               seal_d = 1'b0;
            end
         end
         default: pm_d = PM_SEALED;
      endcase
      backup_en_d = (pm_d == PM_BACKUP);
      on_main_d = (pm_d == PM_MAIN);
      rx_en_d = (pm_d == PM_MAIN);
      trip_mon_d = ~lp_d;
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_q <= BPSC_OUT_CTRL_RST[BPSC_OUT_BIT];
         fsel_q <= BPSC_OUT_CTRL_RST[BPSC_FSEL_BIT];
         trim_q <= BPSC_OUT_CTRL_RST[5:0];
         alme_q <= BPSC_PWR_CTRL_RST[BPSC_ALME_BIT];
         lp_q <= BPSC_PWR_CTRL_RST[BPSC_LP_BIT];
         seal_q <= 1'b1;
         bat_q <= BPSC_PWR_STAT_RST[BPSC_BAT_BIT];
         ploss_q <= BPSC_PWR_STAT_RST[BPSC_PLOSS_BIT];
         pm_q <= PM_SEALED;
         o_backup_en <= 1'b0;
         o_on_main <= 1'b0;
         o_bus_rx_en <= 1'b0;
         o_trip_mon_en <= 1'b1;
      end else begin
         out_q <= out_d;
         fsel_q <= fsel_d;
         trim_q <= trim_d;
         alme_q <= alme_d;
         lp_q <= lp_d;
         seal_q <= seal_d;
         bat_q <= bat_d;
         ploss_q <= ploss_d;
         pm_q <= pm_d;
         o_backup_en <= backup_en_d;
         o_on_main <= on_main_d;
         o_bus_rx_en <= rx_en_d;
         o_trip_mon_en <= trip_mon_d;
      end
   end

   // Output pin: 512Hz square or logic level, runs in every supply mode
   logic [BPSC_FOUT_CNT_W-1:0] fc_q, fc_d;
   logic sq_q, sq_d, fout_oe_d;

   always_comb begin
      fc_d = fc_q + 18'h00001;
      sq_d = sq_q;
      if (fc_q == BPSC_FOUT_CNT_W'(FOUT_HALF - 1)) begin
         fc_d = 18'h00000;
         sq_d = ~sq_q;
      end
      fout_oe_d = fsel_q ? ~sq_q : ~out_q;
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fc_q <= 18'h00000;
         sq_q <= 1'b0;
         o_fout_oe <= 1'b0;
         o_fout_o <= 1'b0;
         o_sda_oe <= 1'b0;
         o_sda_o <= 1'b0;
      end else begin
         fc_q <= fc_d;
         sq_q <= sq_d;
         o_fout_oe <= fout_oe_d;
         o_fout_o <= 1'b0;
         o_sda_oe <= sda_oe_d;
         o_sda_o <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   a_sda_pull_only: assert property (o_sda_oe |-> !o_sda_o)
      else $error("sda driven high");
   a_rx_en_main: assert property (o_bus_rx_en == (pm_q == PM_MAIN))
      else $error("bus receiver enable disagrees with supply mode");
   a_bus_gated_off: assert property ((pm_q != PM_MAIN) |=> !o_sda_oe)
      else $error("sda driven while not on main supply");
   a_enter_needs_both: assert property
      ((pm_q == PM_MAIN && !lp_q && !(lt_bat && lt_trip)) |=> pm_q == PM_MAIN)
      else $error("left main supply without both conditions");
   a_leave_on_either: assert property
      ((pm_q == PM_BACKUP && (gt_bat || (!lp_q && gt_trip))) |=> pm_q == PM_MAIN)
      else $error("stayed in backup with a return condition");
   a_ploss_holds: assert property
      ((ploss_q && !(wr_stb && ptr_q == BPSC_ADDR_PWR_STAT)) |=> ploss_q)
      else $error("power loss flag cleared without a write");
   a_lp_trip_off: assert property (o_trip_mon_en == !lp_q)
      else $error("trip monitor enable wrong for low power mode");
   a_lp_switch: assert property
      ((pm_q == PM_MAIN && lp_q && lt_bat) |=> pm_q != PM_MAIN)
      else $error("low power mode did not switch over");
   a_sealed_no_draw: assert property ((pm_q == PM_SEALED) |-> ##1 !o_backup_en)
      else $error("backup drawn while sealed");
   a_bit_a_path: assert property
      ((pm_q == PM_MAIN && seal_q && lt_bat && lt_trip && !lp_q) |=> pm_q == PM_SEALED)
      else $error("resealed device switched to backup");
   a_fout_level: assert property ((!fsel_q) |=> (o_fout_oe == !$past(out_q)))
      else $error("output pin level mode wrong");

endmodule : bpsc_top
`default_nettype wire

// file: testbench/bpsc_host_model.sv
// Two-wire bus master model with the SDA pull-up.
// Assumes the device only pulls SDA low through its enable.
`timescale 1ns/10ps
`default_nettype none
module bpsc_host_model #(
   parameter int H = 12
) (
   // Clock
   input wire logic i_mclk,
   // Bus pins
   input wire logic i_sda_oe,
   output logic o_scl,
   output logic o_sda
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   assign o_scl = scl_q;
   assign o_sda = sda_q & ~i_sda_oe;
   task automatic hold(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : hold
   task automatic bit_io(input logic b, output logic r);
      hold(3);
      sda_q <= b;
      hold(H);
      scl_q <= 1'b1;
      hold(H);
      @(negedge i_mclk) r = o_sda;
      @(posedge i_mclk) scl_q <= 1'b0;
   endtask : bit_io
   task automatic start();
      hold(H);
      sda_q <= 1'b0;
      hold(H);
      scl_q <= 1'b0;
   endtask : start
   task automatic stop();
      hold(3);
      sda_q <= 1'b0;
      hold(H);
      scl_q <= 1'b1;
      hold(H);
      sda_q <= 1'b1;
      hold(H);
   endtask : stop
   task automatic byte_wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : byte_wr
   task automatic byte_rd(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   endtask : byte_rd
endmodule : bpsc_host_model
`default_nettype wire

// file: testbench/bpsc_top_tb.sv
// Testbench for the supply switchover control.
// Assumes the host model drives the bus; the bench drives the comparator flags.
`timescale 1ns/10ps
`default_nettype none
module bpsc_top_tb;
   import bpsc_pkg::*;
   localparam int HALF = 8;
   logic i_mclk;
   logic i_reset_n;
   logic lt_bat, lt_trip, gt_bat, gt_trip;
   wire scl;
   wire sda;
   logic sda_o, sda_oe, fout_o, fout_oe, bk, mn, rx, tm;
   int miscompares = 0;
   int num_checks = 0;
   logic [7:0] d;
   logic ak;
   int n;
   bpsc_top #(.FOUT_HALF(HALF)) DUT (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_vdd_lt_bat_hys(lt_bat), .i_vdd_lt_trip(lt_trip),
      .i_vdd_gt_bat_hys(gt_bat), .i_vdd_gt_trip_hys(gt_trip),
      .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .o_fout_o(fout_o), .o_fout_oe(fout_oe), .o_backup_en(bk),
      .o_on_main(mn), .o_bus_rx_en(rx), .o_trip_mon_en(tm)
   );
   bpsc_host_model HM (
      .i_mclk(i_mclk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda)
   );
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      logic k;
      HM.start();
      HM.byte_wr({BPSC_SLAVE_ADDR, 1'b0}, k);
      chk(8'(k), 8'h01);
      HM.byte_wr(a, k);
      HM.byte_wr(v, k);
      HM.stop();
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v, output logic k);
      logic j;
      HM.start();
      HM.byte_wr({BPSC_SLAVE_ADDR, 1'b0}, k);
      HM.byte_wr(a, j);
      HM.stop();
      HM.start();
      HM.byte_wr({BPSC_SLAVE_ADDR, 1'b1}, j);
      HM.byte_rd(1'b1, v);
      HM.stop();
   endtask : reg_rd
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      reg_rd(a, d, ak);
      chk(d, e);
   endtask : rc
   task automatic supply(input logic [3:0] f);
      @(posedge i_mclk);
      {lt_bat, lt_trip, gt_bat, gt_trip} <= f;
      repeat (8) @(posedge i_mclk);
   endtask : supply
   task automatic mode(input logic [2:0] e);
      @(negedge i_mclk);
      chk({5'h0, bk, mn, rx}, {5'h0, e});
   endtask : mode
   task automatic half_per(output int c);
      logic p;
      int k;
      c = 0;
      k = 0;
      @(negedge i_mclk) p = fout_oe;
      while (fout_oe === p && k < 40) begin
         @(negedge i_mclk);
         k++;
      end
      p = fout_oe;
      while (fout_oe === p && c < 40) begin
         @(negedge i_mclk);
         c++;
      end
      if (k >= 40 || c >= 40) begin
         miscompares++;
      end
   endtask : half_per
   initial begin
      #360000;
      miscompares++;
      final_report();
   end
   initial begin
      i_reset_n = 1'b0;
      {lt_bat, lt_trip, gt_bat, gt_trip} = 4'h0;
      repeat (12) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({4'h0, bk, mn, rx, fout_oe}, 8'h00);
      chk({7'h0, tm}, 8'h01);
      chk({7'h0, sda_oe}, 8'h00);
      @(posedge i_mclk);
      i_reset_n <= 1'b1;
      supply(4'hC);
      mode(3'b000);
      supply(4'h3);
      mode(3'b011);
      rc(8'h07, 8'h80);
      rc(8'h08, 8'h00);
      rc(8'h0B, 8'h03);
      rc(8'h0C, 8'h00);
      HM.start();
      HM.byte_wr(8'hA0, ak);
      HM.stop();
      chk(8'(ak), 8'h00);
      reg_wr(8'h0B, 8'h00);
      rc(8'h0B, 8'h00);
      reg_wr(8'h07, 8'h00);
      @(negedge i_mclk);
      chk({7'h0, fout_oe}, 8'h01);
      reg_wr(8'h07, 8'h40);
      half_per(n);
      chk(8'(n), 8'(HALF));
      chk({6'h0, sda_o, fout_o}, 8'h00);
      supply(4'h8);
      mode(3'b011);
      supply(4'hC);
      mode(3'b100);
      half_per(n);
      chk(8'(n), 8'(HALF));
      reg_rd(8'h07, d, ak);
      chk(8'(ak), 8'h00);
      supply(4'h1);
      mode(3'b011);
      rc(8'h0B, 8'h02);
      reg_wr(8'h08, 8'h60);
      rc(8'h08, 8'h60);
      chk({7'h0, tm}, 8'h00);
      supply(4'h8);
      mode(3'b100);
      supply(4'h1);
      mode(3'b100);
      supply(4'h2);
      mode(3'b011);
      reg_wr(8'h0B, 8'h20);
      reg_rd(8'h0B, d, ak);
      chk(d & 8'h20, 8'h20);
      supply(4'hC);
      mode(3'b000);
      supply(4'h3);
      mode(3'b011);
      reg_rd(8'h0B, d, ak);
      chk(d & 8'h20, 8'h00);
      final_report();
   end
endmodule : bpsc_top_tb
`default_nettype wire
